// File: src/gocb_pkg.sv
package gocb_pkg;

  // ****************************************
  // Process image layout
  // ****************************************
  localparam int DATA_BYTES = 2;
  localparam int IDX_W = 2;
  localparam logic [7:0] CB_RESET = 8'h00;

  localparam int CB0_CMD = 0;
  localparam int CB0_BCAST = 1;
  localparam int CB0_ADDR_LSB = 2;
  localparam int CB0_ADDR_W = 5;
  localparam int CB0_NEW_DATA = 7;
  localparam int CB1_RACK = 0;
  localparam int CB1_FLUSH = 2;
  localparam int CB1_COPY = 3;

  // ****************************************
  // Buffers, one kilobyte each way
  // ****************************************
  localparam int BUF_DEPTH = 1024;
  localparam int BUF_AW = 10;
  localparam int BUF_CW = 11;

  // ****************************************
  // Concentrator prefixes
  // ****************************************
  localparam int PFX_MAX = 3;
  localparam logic [IDX_W-1:0] PFX_LEN_BCAST = 2'h3;
  localparam logic [IDX_W-1:0] PFX_LEN_ADDR = 2'h1;
  localparam logic [IDX_W-1:0] PFX_LEN_NONE = 2'h0;
  localparam logic [7:0] BCAST_CHAR0 = 8'h30;
  localparam logic [7:0] BCAST_CHAR1 = 8'h30;
  localparam logic [7:0] BCAST_CHAR2 = 8'h42;

  typedef enum logic [5:0] {
    GOCB_IDLE   = 6'h01,
    GOCB_PREFIX = 6'h02,
    GOCB_DIRECT = 6'h04,
    GOCB_FLUSH  = 6'h08,
    GOCB_COPY   = 6'h10,
    GOCB_LOAD   = 6'h20
  } gocb_state_e;

endpackage

// File: src/gocb_buf_if.sv
`timescale 1ns/100ps
interface gocb_buf_if;
  logic wr_en;
  logic [7:0] wr_data;
  logic rd_en;
  logic [7:0] rd_data;
  logic full;
  logic empty;

  modport owner (output wr_en, output wr_data, output rd_en, input rd_data, input full, input empty);
  modport store (input wr_en, input wr_data, input rd_en, output rd_data, output full, output empty);
endinterface

// File: src/gocb_fifo.sv
`timescale 1ns/100ps
module gocb_fifo (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  gocb_buf_if.store bus
);

  logic [7:0] mem [gocb_pkg::BUF_DEPTH];
  logic [gocb_pkg::BUF_AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [gocb_pkg::BUF_CW-1:0] count, next_count;
  logic do_wr, do_rd;

  function automatic logic [gocb_pkg::BUF_AW-1:0] ptr_inc(input logic [gocb_pkg::BUF_AW-1:0] p);
    ptr_inc = p + 10'h001;
  endfunction

  assign bus.rd_data = mem[rd_ptr];
  assign bus.full = (count == 11'h400);
  assign bus.empty = (count == 11'h000);

  always_comb begin
    // Writes to a full store and reads of an empty one are dropped
    do_wr = bus.wr_en && !bus.full;
    do_rd = bus.rd_en && !bus.empty;
    next_wr_ptr = do_wr ? ptr_inc(wr_ptr) : wr_ptr;
    next_rd_ptr = do_rd ? ptr_inc(rd_ptr) : rd_ptr;
    next_count = count;
    if (do_wr && !do_rd) begin
      next_count = count + 11'h001;
    end else if (do_rd && !do_wr) begin
      next_count = count - 11'h001;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (clk_en) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en && do_wr) begin
      mem[wr_ptr] <= bus.wr_data;
    end
  end

endmodule // gocb_fifo

// File: src/gocb_top.sv
`timescale 1ns/100ps
module gocb_top (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [7:0] ctrl_byte_zero,
  input wire logic [7:0] ctrl_byte_one,
  input wire logic [15:0] master_data,
  input wire logic concentrator_present,
  input wire logic [7:0] ser_rx_data,
  input wire logic ser_rx_valid,
  input wire logic ser_tx_ready,
  output logic [7:0] ser_tx_data,
  output logic ser_tx_valid,
  output logic [15:0] in_data,
  output logic block_ready_toggle,
  output logic rx_pending,
  output logic rx_full,
  output logic cmd_active,
  output logic [15:0] cmd_data,
  output logic cmd_strobe
);

  // ****************************************
  // Pin synchronisers and previous samples
  // ****************************************
  logic [32:0] sync1, sync2, prev, next_prev;
  logic [7:0] cb0, cb1, pcb0, pcb1;
  logic [15:0] dat, pdat;
  logic conc;
  logic ev_rack, ev_flush, ev_copy, ev_new;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= '0;
      sync2 <= '0;
      prev <= '0;
    end else if (clk_en) begin
      sync1 <= {concentrator_present, master_data, ctrl_byte_one, ctrl_byte_zero};
      sync2 <= sync1;
      prev <= next_prev;
    end
  end

  always_comb begin
    next_prev = sync2;
    {conc, dat, cb1, cb0} = sync2;
    {pdat, pcb1, pcb0} = prev[31:0];
    ev_rack = cb1[gocb_pkg::CB1_RACK] ^ pcb1[gocb_pkg::CB1_RACK];
    ev_flush = cb1[gocb_pkg::CB1_FLUSH] ^ pcb1[gocb_pkg::CB1_FLUSH];
    ev_copy = cb1[gocb_pkg::CB1_COPY] ^ pcb1[gocb_pkg::CB1_COPY];
    // Changed data is a new set; the toggle covers repeats of identical data
    ev_new = (cb0[gocb_pkg::CB0_NEW_DATA] ^ pcb0[gocb_pkg::CB0_NEW_DATA]) || (dat != pdat);
  end

  // ****************************************
  // Buffers
  // ****************************************
  gocb_buf_if txb ();
  gocb_buf_if rxb ();

  gocb_fifo u_txbuf (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .bus(txb)
  );

  gocb_fifo u_rxbuf (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .bus(rxb)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  gocb_pkg::gocb_state_e state, next_state;
  logic [gocb_pkg::IDX_W-1:0] idx, next_idx, pfx_len, next_pfx_len;
  logic [7:0] pfx [gocb_pkg::PFX_MAX];
  logic [7:0] next_pfx [gocb_pkg::PFX_MAX];
  logic [15:0] snap, next_snap;
  logic from_buf, next_from_buf;
  logic pend_rack, pend_flush, pend_copy, pend_new;
  logic next_pend_rack, next_pend_flush, next_pend_copy, next_pend_new;
  logic [7:0] next_tx_data;
  logic next_tx_valid, can_load, last;
  logic [15:0] next_in_data, next_cmd_data;
  logic next_ready_tgl, next_cmd_strobe;

  function automatic logic [7:0] byte_of(input logic [15:0] w, input logic [gocb_pkg::IDX_W-1:0] i);
    byte_of = i[0] ? w[15:8] : w[7:0];
  endfunction

  always_comb begin
    next_state = state;
    next_idx = idx;
    next_pfx_len = pfx_len;
    next_pfx = pfx;
    next_snap = snap;
    next_from_buf = from_buf;
    next_in_data = in_data;
    next_ready_tgl = block_ready_toggle;
    next_cmd_data = cmd_data;
    next_cmd_strobe = 1'b0;
    next_tx_data = ser_tx_data;
    next_tx_valid = ser_tx_valid && !ser_tx_ready;
    can_load = !ser_tx_valid || ser_tx_ready;
    last = (idx == 2'(gocb_pkg::DATA_BYTES - 1));
    txb.wr_en = 1'b0;
    txb.wr_data = byte_of(snap, idx);
    txb.rd_en = 1'b0;
    rxb.wr_en = ser_rx_valid;
    rxb.wr_data = ser_rx_data;
    rxb.rd_en = 1'b0;
    // A new event always wins over the clear of the same pending flag
    next_pend_rack = pend_rack;
    next_pend_flush = pend_flush;
    next_pend_copy = pend_copy;
    next_pend_new = pend_new;

    // Concentrator prefix follows the live control byte while idle and is held outside GOCB_IDLE
    if (!conc) begin
      next_pfx_len = gocb_pkg::PFX_LEN_NONE;
    end else if (cb0[gocb_pkg::CB0_BCAST]) begin
      next_pfx_len = gocb_pkg::PFX_LEN_BCAST;
      next_pfx[0] = gocb_pkg::BCAST_CHAR0;
      next_pfx[1] = gocb_pkg::BCAST_CHAR1;
      next_pfx[2] = gocb_pkg::BCAST_CHAR2;
    end else begin
      next_pfx_len = gocb_pkg::PFX_LEN_ADDR;
      next_pfx[0] = {3'h0, cb0[gocb_pkg::CB0_ADDR_LSB +: gocb_pkg::CB0_ADDR_W]};
    end
    if (state != gocb_pkg::GOCB_IDLE) begin
      next_pfx_len = pfx_len;
      next_pfx = pfx;
    end

    case (state)
      gocb_pkg::GOCB_IDLE: begin
        next_idx = '0;
        if (pend_rack) begin
          next_pend_rack = 1'b0;
          if (rxb.empty) begin
            next_in_data = '0;
          end else begin
            next_state = gocb_pkg::GOCB_LOAD;
          end
        end else if (pend_flush) begin
          next_pend_flush = 1'b0;
          next_from_buf = 1'b1;
          next_state = (next_pfx_len != '0) ? gocb_pkg::GOCB_PREFIX : gocb_pkg::GOCB_FLUSH;
        end else if (pend_copy) begin
          next_pend_copy = 1'b0;
          next_pend_new = 1'b0;
          next_snap = dat;
          if (!cb0[gocb_pkg::CB0_CMD]) begin
            next_state = gocb_pkg::GOCB_COPY;
          end
        end else if (pend_new) begin
          next_pend_new = 1'b0;
          next_snap = dat;
          if (cb0[gocb_pkg::CB0_CMD]) begin
            next_cmd_data = dat;
            next_cmd_strobe = 1'b1;
          end else begin
            next_from_buf = 1'b0;
            next_state = (next_pfx_len != '0) ? gocb_pkg::GOCB_PREFIX : gocb_pkg::GOCB_DIRECT;
          end
        end
      end
      gocb_pkg::GOCB_PREFIX: begin
        if (can_load) begin
          next_tx_data = pfx[idx];
          next_tx_valid = 1'b1;
          next_idx = idx + 2'h1;
          if (idx == pfx_len - 2'h1) begin
            next_idx = '0;
            next_state = from_buf ? gocb_pkg::GOCB_FLUSH : gocb_pkg::GOCB_DIRECT;
          end
        end
      end
      gocb_pkg::GOCB_DIRECT: begin
        if (can_load) begin
          next_tx_data = byte_of(snap, idx);
          next_tx_valid = 1'b1;
          next_idx = idx + 2'h1;
          if (last) begin
            next_state = gocb_pkg::GOCB_IDLE;
          end
        end
      end
      gocb_pkg::GOCB_FLUSH: begin
        if (can_load) begin
          if (txb.empty) begin
            next_state = gocb_pkg::GOCB_IDLE;
          end else begin
            next_tx_data = txb.rd_data;
            next_tx_valid = 1'b1;
            txb.rd_en = 1'b1;
          end
        end
      end
      gocb_pkg::GOCB_COPY: begin
        txb.wr_en = 1'b1;
        next_idx = idx + 2'h1;
        if (last) begin
          next_state = gocb_pkg::GOCB_IDLE;
        end
      end
      gocb_pkg::GOCB_LOAD: begin
        // Missing bytes at the end of the buffer read as zero
        if (idx[0]) begin
          next_in_data[15:8] = rxb.empty ? 8'h00 : rxb.rd_data;
        end else begin
          next_in_data[7:0] = rxb.empty ? 8'h00 : rxb.rd_data;
        end
        rxb.rd_en = !rxb.empty;
        next_idx = idx + 2'h1;
        if (last) begin
          next_ready_tgl = !block_ready_toggle;
          next_state = gocb_pkg::GOCB_IDLE;
        end
      end
      default: begin
        next_state = gocb_pkg::GOCB_IDLE;
      end
    endcase

    next_pend_rack = next_pend_rack || ev_rack;
    next_pend_flush = next_pend_flush || ev_flush;
    next_pend_copy = next_pend_copy || ev_copy;
    next_pend_new = next_pend_new || ev_new;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= gocb_pkg::GOCB_IDLE;
      idx <= '0;
      pfx_len <= '0;
      pfx <= '{default: 8'h00};
      snap <= '0;
      from_buf <= 1'b0;
      pend_rack <= 1'b0;
      pend_flush <= 1'b0;
      pend_copy <= 1'b0;
      pend_new <= 1'b0;
      ser_tx_data <= '0;
      ser_tx_valid <= 1'b0;
      in_data <= '0;
      block_ready_toggle <= 1'b0;
      rx_pending <= 1'b0;
      rx_full <= 1'b0;
      cmd_active <= 1'b0;
      cmd_data <= '0;
      cmd_strobe <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      idx <= next_idx;
      pfx_len <= next_pfx_len;
      pfx <= next_pfx;
      snap <= next_snap;
      from_buf <= next_from_buf;
      pend_rack <= next_pend_rack;
      pend_flush <= next_pend_flush;
      pend_copy <= next_pend_copy;
      pend_new <= next_pend_new;
      ser_tx_data <= next_tx_data;
      ser_tx_valid <= next_tx_valid;
      in_data <= next_in_data;
      block_ready_toggle <= next_ready_tgl;
      rx_pending <= !rxb.empty;
      rx_full <= rxb.full;
      cmd_active <= cb0[gocb_pkg::CB0_CMD];
      cmd_data <= next_cmd_data;
      cmd_strobe <= next_cmd_strobe;
    end
  end

endmodule // gocb_top

// File: testbench/gocb_serial_model.sv
`timescale 1ns/100ps
// ****************************************
// Serial end device
// ****************************************
module gocb_serial_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic [7:0] ser_tx_data,
  input wire logic ser_tx_valid,
  output logic ser_tx_ready,
  output logic [7:0] ser_rx_data,
  output logic ser_rx_valid
);
  logic [7:0] got[$];
  logic ph;
  initial begin
    ser_tx_ready = 1'b0;
    ser_rx_data = 8'h00;
    ser_rx_valid = 1'b0;
    ph = 1'b0;
  end
  // Slow mode takes a byte only every other cycle
  always @(posedge ref_clk) begin
    if (rstn && ser_tx_valid && ser_tx_ready) got.push_back(ser_tx_data);
    ph <= ~ph;
    ser_tx_ready <= rstn && (!slow || ph);
  end
  task automatic send(input logic [7:0] b);
    @(posedge ref_clk);
    ser_rx_data <= b;
    ser_rx_valid <= 1'b1;
    @(posedge ref_clk);
    ser_rx_valid <= 1'b0;
    // Idle line must not look like the last byte
    ser_rx_data <= ~b;
  endtask
endmodule // gocb_serial_model

// File: testbench/gocb_top_properties.sv
`timescale 1ns/100ps
// ****************************************
// Port checks
// ****************************************
module gocb_top_properties (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic [7:0] ctrl_byte_zero,
  input wire logic [7:0] ctrl_byte_one,
  input wire logic [15:0] master_data,
  input wire logic ser_tx_ready,
  input wire logic [7:0] ser_tx_data,
  input wire logic ser_tx_valid,
  input wire logic [15:0] in_data,
  input wire logic block_ready_toggle,
  input wire logic rx_pending,
  input wire logic rx_full,
  input wire logic cmd_active,
  input wire logic cmd_strobe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Cycles since a pin change, saturating; frozen with the clock enable
  logic [25:0] pins;
  logic [25:0] last;
  logic last_ack;
  logic [5:0] n_pin;
  logic [5:0] n_ack;
  assign pins = {ctrl_byte_zero, ctrl_byte_one[3:2], master_data};
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      last <= '0;
      last_ack <= 1'b0;
      n_pin <= 6'h3f;
      n_ack <= 6'h3f;
    end else if (clk_en) begin
      last <= pins;
      last_ack <= ctrl_byte_one[0];
      n_pin <= (pins != last) ? 6'h00 : n_pin + {5'h00, n_pin != 6'h3f};
      n_ack <= (ctrl_byte_one[0] != last_ack) ? 6'h00 : n_ack + {5'h00, n_ack != 6'h3f};
    end
  end
  property p_tx_hold;
    ser_tx_valid && !ser_tx_ready |=> ser_tx_valid && $stable(ser_tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx byte lost before taken");
  property p_full_pend;
    rx_full |-> rx_pending;
  endproperty
  a_full_pend: assert property (p_full_pend) else $error("full but not pending");
  property p_rst_quiet;
    $rose(rstn) |-> !ser_tx_valid && !cmd_strobe && !block_ready_toggle && in_data == 16'h0000;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
  property p_strobe_pulse;
    cmd_strobe |=> !cmd_strobe;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("command strobe too long");
  property p_strobe_cmd;
    cmd_strobe |-> cmd_active;
  endproperty
  a_strobe_cmd: assert property (p_strobe_cmd) else $error("strobe outside command mode");
  property p_strobe_cause;
    cmd_strobe |-> n_pin < 6'h0c;
  endproperty
  a_strobe_cause: assert property (p_strobe_cause) else $error("strobe without new data");
  property p_ready_cause;
    $changed(block_ready_toggle) |-> n_ack < 6'h0c;
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("block ready without ack");
  property p_in_cause;
    $changed(in_data) |-> n_ack < 6'h0c;
  endproperty
  a_in_cause: assert property (p_in_cause) else $error("input data moved without ack");
  property p_tx_cause;
    $rose(ser_tx_valid) |-> n_pin < 6'h0c;
  endproperty
  a_tx_cause: assert property (p_tx_cause) else $error("serial send without event");
endmodule // gocb_top_properties
bind gocb_top gocb_top_properties u_prop (.ref_clk, .rstn, .clk_en, .ctrl_byte_zero, .ctrl_byte_one,
  .master_data, .ser_tx_ready, .ser_tx_data, .ser_tx_valid, .in_data, .block_ready_toggle, .rx_pending,
  .rx_full, .cmd_active, .cmd_strobe);

// File: testbench/gocb_top_tb_top.sv
`timescale 1ns/100ps
module gocb_top_tb_top;
  logic ref_clk, rstn, clk_en, conc, slow, rxv, txv, txr, rdy_tgl, pend, full, cact, cstb;
  logic [7:0] c0, c1, rxd, txd;
  logic [15:0] md, ind, cdat, cmd_seen;
  logic [7:0] exp[$];
  int n_fail, checks;
  gocb_top dut (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .ctrl_byte_zero(c0),
    .ctrl_byte_one(c1), .master_data(md), .concentrator_present(conc), .ser_rx_data(rxd),
    .ser_rx_valid(rxv), .ser_tx_ready(txr), .ser_tx_data(txd), .ser_tx_valid(txv), .in_data(ind),
    .block_ready_toggle(rdy_tgl), .rx_pending(pend), .rx_full(full), .cmd_active(cact), .cmd_data(cdat),
    .cmd_strobe(cstb));
  gocb_serial_model m (.ref_clk(ref_clk), .rstn(rstn), .slow(slow), .ser_tx_data(txd),
    .ser_tx_valid(txv), .ser_tx_ready(txr), .ser_rx_data(rxd), .ser_rx_valid(rxv));
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (cstb === 1'b1) cmd_seen <= cdat;
  // ****************************************
  // Compare and drive
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    checks++;
    if (got !== want) begin
      n_fail++;
      $display("MISMATCH %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic chk_tx();
    chk(16'(m.got.size()), 16'(exp.size()));
    foreach (exp[i]) if (i < m.got.size()) chk({8'h00, m.got[i]}, {8'h00, exp[i]});
    m.got.delete();
    exp.delete();
  endtask
  // Waits until the serial side has been quiet for 15 cycles
  task automatic put(input logic [7:0] a, input logic [7:0] b, input logic [15:0] d);
    int q;
    @(posedge ref_clk);
    c0 <= a;
    c1 <= b;
    md <= d;
    q = 0;
    repeat (200) begin
      @(posedge ref_clk);
      q = (txv === 1'b1) ? 0 : q + 1;
      if (q > 14) break;
    end
    if (q <= 14) begin
      n_fail++;
      $display("MISMATCH %0t serial side never went quiet", $time);
    end
    @(negedge ref_clk);
  endtask
  task automatic final_report();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #200us;
    n_fail++;
    final_report();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    {rstn, conc, c0, c1, md, cmd_seen, n_fail, checks} = '0;
    clk_en = 1'b1;
    slow = 1'b1;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    @(negedge ref_clk);
    chk({11'h000, txv, rdy_tgl, pend, full, cstb}, 16'h0000);
    put(8'h80, 8'h00, 16'h2b41);
    exp = '{8'h41, 8'h2b};
    chk_tx();
    put(8'h00, 8'h00, 16'h2b41);
    exp = '{8'h41, 8'h2b};
    chk_tx();
    @(posedge ref_clk);
    conc <= 1'b1;
    put(8'hcc, 8'h00, 16'h2b41);
    exp = '{8'h13, 8'h41, 8'h2b};
    chk_tx();
    put(8'h02, 8'h00, 16'h2b41);
    exp = '{8'h30, 8'h30, 8'h42, 8'h41, 8'h2b};
    chk_tx();
    @(posedge ref_clk);
    conc <= 1'b0;
    put(8'hce, 8'h00, 16'h2b41);
    exp = '{8'h41, 8'h2b};
    chk_tx();
    put(8'h01, 8'h00, 16'h0c02);
    chk_tx();
    chk({15'h0000, cact}, 16'h0001);
    chk(cmd_seen, 16'h0c02);
    put(8'h00, 8'h08, 16'h5453);
    chk_tx();
    chk({15'h0000, cact}, 16'h0000);
    put(8'h00, 8'h00, 16'h0a0d);
    chk_tx();
    put(8'h00, 8'h04, 16'h0a0d);
    exp = '{8'h53, 8'h54, 8'h0d, 8'h0a};
    chk_tx();
    @(posedge ref_clk);
    slow <= 1'b0;
    m.send(8'h11);
    m.send(8'h22);
    m.send(8'h33);
    put(8'h00, 8'h05, 16'h0a0d);
    chk(ind, 16'h2211);
    chk({15'h0000, rdy_tgl}, 16'h0001);
    put(8'h00, 8'h04, 16'h0a0d);
    chk(ind, 16'h0033);
    chk({14'h0000, rdy_tgl, pend}, 16'h0000);
    // A frozen clock enable must hold the event back
    @(posedge ref_clk);
    clk_en <= 1'b0;
    put(8'h00, 8'h05, 16'h0a0d);
    chk(ind, 16'h0033);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    put(8'h00, 8'h05, 16'h0a0d);
    chk(ind, 16'h0000);
    chk({15'h0000, rdy_tgl}, 16'h0000);
    repeat (1024) m.send(8'h5a);
    put(8'h00, 8'h05, 16'h0a0d);
    chk({15'h0000, full}, 16'h0001);
    @(posedge ref_clk);
    c1 <= 8'h00;
    md <= 16'h0000;
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    put(8'h00, 8'h00, 16'h0000);
    chk(ind, 16'h0000);
    chk({13'h0000, full, pend, rdy_tgl}, 16'h0000);
    final_report();
  end
endmodule // gocb_top_tb_top
